// ===== src/mic_defs.svh
// offsets, field positions and reset values for the interrupt controller
`ifndef MIC_DEFS_SVH
`define MIC_DEFS_SVH

// source count and vector count
`define MIC_NUM_SRC 21
`define MIC_NUM_VEC 10

// source positions in the request vector
`define MIC_SRC_CMP_TWO 0
`define MIC_SRC_CMP_SEVEN 1
`define MIC_SRC_CMP_THREE 2
`define MIC_SRC_CMP_EIGHT 3
`define MIC_SRC_EXT_TWO 4
`define MIC_SRC_T0_LOW 5
`define MIC_SRC_EXT_FOUR 6
`define MIC_SRC_EXT_THREE 7
`define MIC_SRC_BASE_TMR 8
`define MIC_SRC_T0_HIGH 9
`define MIC_SRC_T1_LOW 10
`define MIC_SRC_T1_HIGH 11
`define MIC_SRC_UART_RX 12
`define MIC_SRC_SYNC_SER 13
`define MIC_SRC_UART_TX 14
`define MIC_SRC_ADC 15
`define MIC_SRC_T6 16
`define MIC_SRC_T7 17
`define MIC_SRC_CMP1_TO 18
`define MIC_SRC_CMP_SIX 19
`define MIC_SRC_SURGE 20

// first source of each vector; sources of a vector are contiguous
`define MIC_VEC1_FIRST 2
`define MIC_VEC2_FIRST 4
`define MIC_VEC3_FIRST 7
`define MIC_VEC4_FIRST 9
`define MIC_VEC5_FIRST 10
`define MIC_VEC6_FIRST 12
`define MIC_VEC7_FIRST 13
`define MIC_VEC8_FIRST 15
`define MIC_VEC9_FIRST 19

// vector addresses: base plus a fixed stride
`define MIC_VEC_BASE 20'h00003
`define MIC_VEC_STRIDE 20'h00008

// number of vectors whose upper level is top rather than high
`define MIC_NUM_TOP_VEC 2

// service level encodings, none below low
`define MIC_LVL_NONE 2'h0
`define MIC_LVL_LOW 2'h1
`define MIC_LVL_HIGH 2'h2
`define MIC_LVL_TOP 2'h3

// nesting depth of the service level stack
`define MIC_STACK_DEPTH 3

`endif

// ===== src/mic_pkg.sv
// types shared by the interrupt controller modules
package mic_pkg;

    typedef logic [1:0] mic_level_t;

    typedef enum logic [1:0] {
        MIC_RUN,
        MIC_IDLE,
        MIC_SLEEP
    } mic_mode_t;

endpackage

// ===== src/mic_arb_if.sv
// carrier between the controller core and its arbiter
`timescale 1ns/1ps
interface mic_arb_if #(
    parameter int NUM_VEC = 10,
    parameter int IDX_W = 4
);
    logic [NUM_VEC-1:0] vec_pend;
    mic_pkg::mic_level_t vec_lvl [NUM_VEC];
    mic_pkg::mic_level_t cur_level;
    logic win_valid;
    logic [IDX_W-1:0] win_idx;
    mic_pkg::mic_level_t win_lvl;

    modport arb (
        input vec_pend,
        input vec_lvl,
        input cur_level,
        output win_valid,
        output win_idx,
        output win_lvl
    );

    modport ctl (
        output vec_pend,
        output vec_lvl,
        output cur_level,
        input win_valid,
        input win_idx,
        input win_lvl
    );
endinterface

// ===== src/mic_arbiter.sv
// priority pick among pending vectors: level first, then lowest address
`timescale 1ns/1ps
`include "mic_defs.svh"
module mic_arbiter #(
    parameter int NUM_VEC = 10,
    parameter int IDX_W = 4
) (
    // request and answer bundle
    mic_arb_if.arb arb
);
    mic_pkg::mic_level_t best_lvl;
    logic [IDX_W-1:0] best_idx;
    logic found;

    // the winner index must be able to name every vector
    if (NUM_VEC < 1 || (2 ** IDX_W) < NUM_VEC) begin : g_bad_width
        $error("mic_arbiter: index width too narrow for the vector count");
    end

    // descending scan with >= lets the lower address win a tie
    always_comb begin
        best_lvl = `MIC_LVL_NONE;
        best_idx = '0;
        found = 1'b0;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (arb.vec_pend[i] && (arb.vec_lvl[i] >= best_lvl)) begin
                best_lvl = arb.vec_lvl[i];
                best_idx = IDX_W'(i);
                found = 1'b1;
            end
        end
    end

    // nothing at or below the level in service gets through
    assign arb.win_valid = found && (best_lvl > arb.cur_level);
    assign arb.win_idx = best_idx;
    assign arb.win_lvl = best_lvl;
endmodule // mic_arbiter

// ===== src/mic_irq_ctrl.sv
// multilevel vectored interrupt controller with idle and deep-sleep wake
`timescale 1ns/1ps
`include "mic_defs.svh"

// How it works
// - three nested levels top, high, low; every vector requests at one
// - a request at or below the level in service waits for its end
// - among pending vectors the highest level is granted
// - on equal levels the smallest vector address is granted
// - 21 sources fold onto 10 vectors, the first at 00003H
// - vector 00003H serves comparators two and seven, top or low
// - vector 0000BH serves comparators three and eight, top or low
// - vector 00013H serves pin two, timer zero low, pin four
// - vector 0001BH serves pin three and the base timer
// - vector 00033H serves the serial receiver alone
// - vector 0003BH serves synchronous serial and serial transmitter
// - vector 00043H serves converter, timers six, seven, pulse timeout
// - vector 0004BH serves comparator six and surge detection
// - idle stops the core, peripherals run, oscillators run unless stopped
// - idle ends on reset pin, watchdog, low-voltage reset or any enabled request
// - deep sleep stops core, peripherals and all internal oscillators
// - deep sleep ends on reset causes or pin request two or four
module mic_irq_ctrl #(
    parameter int NUM_SRC = `MIC_NUM_SRC,
    parameter int NUM_VEC = `MIC_NUM_VEC
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    // peripheral request pulses, enables and flag clears
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic [NUM_SRC-1:0] src_en,
    input wire logic [NUM_SRC-1:0] src_clr,
    // per vector: 1 selects the upper level, 0 selects low
    input wire logic [NUM_VEC-1:0] vec_level_sel,
    // processor core side
    input wire logic irq_ack,
    input wire logic irq_ret,
    output logic irq_req,
    output logic [19:0] irq_vec_addr,
    output mic_pkg::mic_level_t irq_level,
    output mic_pkg::mic_level_t service_level,
    output logic [NUM_SRC-1:0] src_flags,
    // standby control
    input wire logic idle_enter,
    input wire logic sleep_enter,
    input wire logic osc_stop_sw,
    input wire logic reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic low_voltage_reset,
    output logic cpu_run,
    output logic periph_run,
    output logic osc_run,
    output mic_pkg::mic_mode_t standby_mode
);

    localparam int IDX_W = $clog2(NUM_VEC);
    // one count more than the depth so a full stack shows
    localparam int SP_W = $clog2(`MIC_STACK_DEPTH + 1);

    // the source to vector folding is fixed in hardware
    if (NUM_SRC != `MIC_NUM_SRC || NUM_VEC != `MIC_NUM_VEC) begin : g_bad_counts
        $error("mic_irq_ctrl: source and vector counts are fixed at 21 and 10");
    end
    // three strictly rising levels must fit on the stack
    if (`MIC_STACK_DEPTH < 3) begin : g_bad_depth
        $error("mic_irq_ctrl: the level stack needs three entries");
    end

    // vector that a source folds onto
    function automatic int vec_of_src(input int s);
        int v;
        v = 0;
        // descending compare: each source lands in the last group it reaches
        if (s >= `MIC_VEC9_FIRST) begin
            v = 9;
        end else if (s >= `MIC_VEC8_FIRST) begin
            v = 8;
        end else if (s >= `MIC_VEC7_FIRST) begin
            v = 7;
        end else if (s >= `MIC_VEC6_FIRST) begin
            v = 6;
        end else if (s >= `MIC_VEC5_FIRST) begin
            v = 5;
        end else if (s >= `MIC_VEC4_FIRST) begin
            v = 4;
        end else if (s >= `MIC_VEC3_FIRST) begin
            v = 3;
        end else if (s >= `MIC_VEC2_FIRST) begin
            v = 2;
        end else if (s >= `MIC_VEC1_FIRST) begin
            v = 1;
        end
        return v;
    endfunction

    // address of a vector index
    // vectors sit eight bytes apart from the first
    function automatic logic [19:0] vec_addr(input logic [IDX_W-1:0] idx);
        logic [19:0] wide_idx;
        wide_idx = 20'(idx);
        return `MIC_VEC_BASE + wide_idx * `MIC_VEC_STRIDE;
    endfunction

    // level that a vector requests at
    // the two comparator vectors trade high for top
    function automatic mic_pkg::mic_level_t vec_level(input int v, input logic upper);
        mic_pkg::mic_level_t lvl;
        lvl = `MIC_LVL_LOW;
        if (upper) begin
            lvl = (v < `MIC_NUM_TOP_VEC) ? `MIC_LVL_TOP : `MIC_LVL_HIGH;
        end
        return lvl;
    endfunction

    // request flags and service level stack
    logic [NUM_SRC-1:0] flag_r;
    mic_pkg::mic_level_t cur_level_r;
    mic_pkg::mic_level_t stack_r [`MIC_STACK_DEPTH];
    logic [SP_W-1:0] sp_r;
    // presented request
    logic irq_req_r;
    logic [19:0] irq_vec_addr_r;
    mic_pkg::mic_level_t irq_level_r;
    // standby mode and run enables
    mic_pkg::mic_mode_t mode_r;
    mic_pkg::mic_mode_t mode_nxt;
    logic cpu_run_r;
    logic periph_run_r;
    logic osc_run_r;

    // combinational helpers
    logic [NUM_SRC-1:0] live_src;
    logic [NUM_VEC-1:0] vec_pend;
    logic any_reset;
    logic any_pending;
    logic sleep_wake;
    logic ack_taken;

    // arbitration is purely combinational from the flags
    mic_arb_if #(.NUM_VEC(NUM_VEC), .IDX_W(IDX_W)) arb_bus ();

    mic_arbiter #(
        .NUM_VEC(NUM_VEC),
        .IDX_W(IDX_W)
    ) u_arbiter (
        .arb(arb_bus)
    );

    // fold enabled flags onto vectors
    assign live_src = flag_r & src_en;

    always_comb begin
        vec_pend = '0;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (live_src[s]) begin
                vec_pend[vec_of_src(s)] = 1'b1;
            end
        end
    end

    assign arb_bus.vec_pend = vec_pend;
    assign arb_bus.cur_level = cur_level_r;

    // first two vectors choose top or low, the rest high or low
    always_comb begin
        for (int v = 0; v < NUM_VEC; v++) begin
            arb_bus.vec_lvl[v] = vec_level(v, vec_level_sel[v]);
        end
    end

    // any reset cause ends standby and empties the service stack
    assign any_reset = !reset_pin_n || watchdog_reset || low_voltage_reset;
    assign any_pending = |vec_pend;
    assign sleep_wake = live_src[`MIC_SRC_EXT_TWO] || live_src[`MIC_SRC_EXT_FOUR];
    assign ack_taken = irq_ack && irq_req_r;

    // request flags; a new request beats a clear in the same cycle
    // flags latch even while disabled, so a later enable still sees them
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flag_r <= '0;
        end else if (clk_en) begin
            flag_r <= (flag_r & ~src_clr) | src_req;
        end
    end

    // service level stack; an accept in the same cycle as a return wins
    // a reset cause empties the stack but keeps the flags, so pending work survives
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cur_level_r <= `MIC_LVL_NONE;
            sp_r <= '0;
            for (int i = 0; i < `MIC_STACK_DEPTH; i++) begin
                stack_r[i] <= `MIC_LVL_NONE;
            end
        end else if (clk_en) begin
            if (any_reset) begin
                cur_level_r <= `MIC_LVL_NONE;
                sp_r <= '0;
            end else if (ack_taken) begin
                // strictly rising levels bound the nesting at three
                if (sp_r < SP_W'(`MIC_STACK_DEPTH)) begin
                    stack_r[sp_r] <= cur_level_r;
                    sp_r <= sp_r + SP_W'(1);
                end
                cur_level_r <= irq_level_r;
            // a return with an empty stack is ignored
            end else if (irq_ret && sp_r != '0) begin
                cur_level_r <= stack_r[sp_r - SP_W'(1)];
                sp_r <= sp_r - SP_W'(1);
            end
        end
    end

    // presented request; dropped at once on acceptance so it is not taken twice
    // the core acks a cycle late, so a higher arrival may still replace the winner
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_req_r <= 1'b0;
            irq_vec_addr_r <= `MIC_VEC_BASE;
            irq_level_r <= `MIC_LVL_NONE;
        end else if (clk_en) begin
            if (ack_taken || any_reset) begin
                irq_req_r <= 1'b0;
            end else begin
                irq_req_r <= arb_bus.win_valid;
                irq_vec_addr_r <= vec_addr(arb_bus.win_idx);
                irq_level_r <= arb_bus.win_lvl;
            end
        end
    end

    // standby mode
    // idle wakes on any enabled flag, even one held back by the level in service
    // sleep listens only to the two pin requests; other flags still latch
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            mic_pkg::MIC_RUN: begin
                if (sleep_enter) begin
                    mode_nxt = mic_pkg::MIC_SLEEP;
                end else if (idle_enter) begin
                    mode_nxt = mic_pkg::MIC_IDLE;
                end
            end
            mic_pkg::MIC_IDLE: begin
                if (any_reset || any_pending) begin
                    mode_nxt = mic_pkg::MIC_RUN;
                end
            end
            mic_pkg::MIC_SLEEP: begin
                if (any_reset || sleep_wake) begin
                    mode_nxt = mic_pkg::MIC_RUN;
                end
            end
            default: begin
                mode_nxt = mic_pkg::MIC_RUN;
            end
        endcase
        if (any_reset) begin
            mode_nxt = mic_pkg::MIC_RUN;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_r <= mic_pkg::MIC_RUN;
        end else if (clk_en) begin
            mode_r <= mode_nxt;
        end
    end

    // run enables follow the next mode so they change with it
    // software oscillator stop is honoured in every mode, not only in idle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cpu_run_r <= 1'b1;
            periph_run_r <= 1'b1;
            osc_run_r <= 1'b1;
        end else if (clk_en) begin
            cpu_run_r <= (mode_nxt == mic_pkg::MIC_RUN);
            periph_run_r <= (mode_nxt != mic_pkg::MIC_SLEEP);
            osc_run_r <= (mode_nxt != mic_pkg::MIC_SLEEP) && !osc_stop_sw;
        end
    end

    // outputs
    // every output is a flop; no input reaches a pin unregistered
    assign irq_req = irq_req_r;
    assign irq_vec_addr = irq_vec_addr_r;
    assign irq_level = irq_level_r;
    assign service_level = cur_level_r;
    assign src_flags = flag_r;
    assign cpu_run = cpu_run_r;
    assign periph_run = periph_run_r;
    assign osc_run = osc_run_r;
    assign standby_mode = mode_r;

endmodule // mic_irq_ctrl

// ===== dv/mic_core_model.sv
// behavioural processor core that takes vectors and returns on command
`timescale 1ns/1ps
module mic_core_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // controller side
    input wire logic irq_req,
    output logic irq_ack = 1'b0,
    output logic irq_ret = 1'b0,
    // bench control
    input wire logic ack_en,
    input wire logic ret_cmd
);
    // one-cycle ack, so a held request is taken only once
    always @(posedge ref_clk) begin
        irq_ack <= !srst && ack_en && irq_req && !irq_ack;
        irq_ret <= !srst && ret_cmd;
    end
endmodule // mic_core_model

// ===== dv/mic_irq_assertions.sv
// port checks for the interrupt controller
`timescale 1ns/1ps
module mic_irq_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // requests
    input wire logic [20:0] src_req,
    input wire logic [20:0] src_en,
    input wire logic [20:0] src_flags,
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic [19:0] irq_vec_addr,
    input wire mic_pkg::mic_level_t irq_level,
    input wire mic_pkg::mic_level_t service_level,
    // standby
    input wire logic reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic low_voltage_reset,
    input wire mic_pkg::mic_mode_t standby_mode,
    input wire logic cpu_run,
    input wire logic periph_run,
    input wire logic osc_run
);
    logic cause;
    assign cause = !reset_pin_n || watchdog_reset || low_voltage_reset;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    req_late_a: assert property (
        |(src_req & src_en) && !irq_req && service_level == 2'h0 && !cause
        && standby_mode == mic_pkg::MIC_RUN |-> ##2 (irq_req || service_level != 2'h0))
        else $error("request not presented in time");
    refuse_low_a: assert property (
        irq_req |-> irq_level > service_level) else $error("request at or below service");
    ack_level_a: assert property (
        irq_ack && irq_req && !cause |=> service_level == $past(irq_level))
        else $error("service level not raised");
    addr_form_a: assert property (
        irq_req |-> irq_vec_addr[2:0] == 3'h3 && irq_vec_addr <= 20'h0004b)
        else $error("bad vector address");
    top_vec_a: assert property (
        irq_req && irq_level == 2'h3 |-> irq_vec_addr <= 20'h0000b) else $error("top misplaced");
    sleep_off_a: assert property (
        standby_mode == mic_pkg::MIC_SLEEP |-> !cpu_run && !periph_run && !osc_run)
        else $error("sleep left something running");
    idle_core_a: assert property (
        standby_mode == mic_pkg::MIC_IDLE |-> !cpu_run && periph_run) else $error("idle wrong");
    sleep_hold_a: assert property (
        standby_mode == mic_pkg::MIC_SLEEP && !cause && !(src_flags[4] && src_en[4])
        && !(src_flags[6] && src_en[6]) |=> standby_mode == mic_pkg::MIC_SLEEP)
        else $error("sleep left without cause");
    idle_wake_a: assert property (
        standby_mode == mic_pkg::MIC_IDLE && |(src_flags & src_en)
        |=> standby_mode == mic_pkg::MIC_RUN && cpu_run) else $error("idle not woken");
    cause_wake_a: assert property (
        standby_mode != mic_pkg::MIC_RUN && cause |=> standby_mode == mic_pkg::MIC_RUN)
        else $error("reset cause did not wake");
    cover property (irq_ack && irq_req && irq_level == 2'h3);
    cover property (standby_mode == mic_pkg::MIC_SLEEP ##1 standby_mode == mic_pkg::MIC_RUN);
    cover property (service_level == 2'h1 && irq_req);
endmodule // mic_irq_checker
bind mic_irq_ctrl mic_irq_checker i_mic_irq_checker (.ref_clk(ref_clk), .srst(srst),
    .src_req(src_req), .src_en(src_en), .src_flags(src_flags), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_vec_addr(irq_vec_addr), .irq_level(irq_level),
    .service_level(service_level), .reset_pin_n(reset_pin_n), .watchdog_reset(watchdog_reset),
    .low_voltage_reset(low_voltage_reset), .standby_mode(standby_mode), .cpu_run(cpu_run),
    .periph_run(periph_run), .osc_run(osc_run));

// ===== dv/testbench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module testbench;
    logic ref_clk, srst, ack_en, ret_cmd, irq_ack, irq_ret, irq_req, cpu_run, periph_run;
    logic idle_enter, sleep_enter, reset_pin_n, watchdog_reset, low_voltage_reset, osc_run;
    logic [20:0] src_req, src_clr, src_flags, src_en;
    logic osc_stop_sw;
    logic [9:0] vec_level_sel;
    logic [19:0] irq_vec_addr;
    mic_pkg::mic_level_t irq_level, service_level;
    mic_pkg::mic_mode_t standby_mode;
    logic [21:0] exp_q[$];
    logic [31:0] seed;
    int fails, checked;
    mic_irq_ctrl i_mic_irq_ctrl (.ref_clk(ref_clk), .srst(srst), .clk_en(1'b1),
        .src_req(src_req), .src_en(src_en), .src_clr(src_clr), .irq_ack(irq_ack),
        .vec_level_sel(vec_level_sel), .irq_ret(irq_ret), .irq_req(irq_req),
        .irq_vec_addr(irq_vec_addr), .irq_level(irq_level), .service_level(service_level),
        .src_flags(src_flags), .idle_enter(idle_enter), .sleep_enter(sleep_enter),
        .osc_stop_sw(osc_stop_sw), .reset_pin_n(reset_pin_n), .watchdog_reset(watchdog_reset),
        .low_voltage_reset(low_voltage_reset), .cpu_run(cpu_run), .periph_run(periph_run),
        .osc_run(osc_run), .standby_mode(standby_mode));
    mic_core_model i_mic_core_model (.ref_clk(ref_clk), .srst(srst), .irq_req(irq_req),
        .irq_ack(irq_ack), .irq_ret(irq_ret), .ack_en(ack_en), .ret_cmd(ret_cmd));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // expected {address, level} of a lone source; sources of a vector are adjacent
    function automatic logic [21:0] expect_of(input int s, input logic [9:0] sel);
        int firsts[9] = '{2, 4, 7, 9, 10, 12, 13, 15, 19};
        int v;
        v = 0;
        foreach (firsts[i]) if (s >= firsts[i]) v = i + 1;
        return {20'h00003 + 20'(8 * v), sel[v] ? (v < 2 ? 2'h3 : 2'h2) : 2'h1};
    endfunction
    function automatic logic [7:0] mode_now();
        return {standby_mode, cpu_run, periph_run, osc_run, 3'h0};
    endfunction
    function automatic logic [7:0] svc_now();
        return {5'h0, irq_req, service_level};
    endfunction
    task automatic tally_and_finish();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp_vec(input logic [21:0] e, input logic [21:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR t=%0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_flags(input logic [20:0] g, input logic [20:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR t=%0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_state(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR t=%0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic pulse_req(input logic [20:0] b);
        src_req <= b;
        tick(1);
        src_req <= '0;
    endtask
    // bounded, so a lost request counts as a mismatch instead of a hang
    task automatic wait_ack();
        int n;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (!(irq_ack === 1'b1 && irq_req === 1'b1) && n < 60);
        if (n >= 60) cmp_vec(22'h1, 22'h0);
    endtask
    task automatic clear_ret(input logic [20:0] b, input logic r);
        src_clr <= b;
        ret_cmd <= r;
        tick(1);
        src_clr <= '0;
        ret_cmd <= 1'b0;
        tick(2);
    endtask
    task automatic enter(input logic sl);
        sleep_enter <= sl;
        idle_enter <= !sl;
        tick(1);
        sleep_enter <= 1'b0;
        idle_enter <= 1'b0;
        tick(1);
    endtask
    always @(posedge ref_clk) begin
        if (!srst && irq_ack === 1'b1 && irq_req === 1'b1) begin
            if (exp_q.size() == 0) cmp_vec(22'h0, {irq_vec_addr, irq_level});
            else cmp_vec(exp_q.pop_front(), {irq_vec_addr, irq_level});
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        #40000;
        fails++;
        tally_and_finish();
    end
    initial begin
        srst = 1'b1;
        {ack_en, ret_cmd, idle_enter, sleep_enter, watchdog_reset, low_voltage_reset} = '0;
        {src_req, src_clr, vec_level_sel} = '0;
        src_en = '1;
        osc_stop_sw = 1'b0;
        reset_pin_n = 1'b1;
        seed = 32'h4a7a;
        tick(6);
        srst <= 1'b0;
        ack_en <= 1'b1;
        for (int s = 0; s < 21; s++) begin
            seed = lfsr(seed);
            vec_level_sel <= seed[9:0];
            exp_q.push_back(expect_of(s, seed[9:0]));
            pulse_req(21'(1) << s);
            wait_ack();
            clear_ret(21'(1) << s, 1'b1);
        end
        $display("test single sources done");
        ack_en <= 1'b0;
        vec_level_sel <= 10'h140;
        exp_q = '{{20'h00033, 2'h2}, {20'h00043, 2'h2}, {20'h00003, 2'h1}, {20'h0000b, 2'h3}};
        pulse_req(21'h009001);
        tick(2);
        ack_en <= 1'b1;
        wait_ack();
        tick(4);
        cmp_state(svc_now(), 8'h02);
        clear_ret(21'h001000, 1'b1);
        wait_ack();
        clear_ret(21'h008000, 1'b1);
        wait_ack();
        vec_level_sel <= 10'h142;
        pulse_req(21'h000004);
        wait_ack();
        tick(2);
        cmp_state(svc_now(), 8'h03);
        clear_ret(21'h000004, 1'b1);
        cmp_state(svc_now(), 8'h01);
        clear_ret(21'h000001, 1'b1);
        // a disabled source latches its flag but is not presented until enabled
        src_en <= ~21'h000200;
        pulse_req(21'h000200);
        tick(3);
        cmp_flags(src_flags, 21'h000200);
        cmp_state(svc_now(), 8'h00);
        exp_q.push_back({20'h00023, 2'h1});
        src_en <= '1;
        wait_ack();
        clear_ret(21'h000200, 1'b1);
        cmp_flags(src_flags, 21'h000000);
        $display("test priority and nesting done");
        ack_en <= 1'b0;
        enter(1'b1);
        cmp_state(mode_now(), 8'h80);
        pulse_req(21'h001000);
        tick(4);
        cmp_state(mode_now(), 8'h80);
        pulse_req(21'h000040);
        tick(3);
        cmp_state(mode_now(), 8'h38);
        clear_ret(21'h1fffff, 1'b0);
        enter(1'b0);
        cmp_state(mode_now(), 8'h58);
        osc_stop_sw <= 1'b1;
        tick(2);
        cmp_state(mode_now(), 8'h50);
        osc_stop_sw <= 1'b0;
        pulse_req(21'h008000);
        tick(3);
        cmp_state(mode_now(), 8'h38);
        clear_ret(21'h1fffff, 1'b0);
        for (int c = 0; c < 3; c++) begin
            enter(c[0]);
            reset_pin_n <= (c != 0);
            watchdog_reset <= (c == 1);
            low_voltage_reset <= (c == 2);
            tick(1);
            {watchdog_reset, low_voltage_reset} <= 2'h0;
            reset_pin_n <= 1'b1;
            tick(2);
            cmp_state(mode_now(), 8'h38);
        end
        $display("test standby done");
        cmp_vec(22'(exp_q.size()), 22'h0);
        tally_and_finish();
    end
endmodule // testbench
